// ==== common/pcp_pkg.sv ====
// constants and types for the paged two-wire control port
// assumes one 250 MHz clock; bus pins arrive asynchronously
// Contract
// - each written data byte is acknowledged, pointer advances by one
// - after read address acknowledge, device returns byte at pointer
// - multi-byte read: host acknowledges all but last, pointer advances per byte
// - target works at standard and fast bus rates
// - book_select selects book only while page is 0x00
// - page_select on any page selects the page
// - reads leave checksums alone; every qualifying write, even unmapped, updates them
// - 8-bit CRC and XOR run together; writing location reloads it
// - CRC polynomial 0x7, x^8+x^2+x+1, order sensitive
// - CRC covers all writes except book and page selection
// - CRC read at 0x7E page zero any book; writing 0x00 resets
// - XOR checksum xors each qualifying written byte into itself
// - XOR counts only book 0x8C, not page selects or page 0x00
// - XOR read at 0x7D page 0x00 book 0x8C; writing 0x00 resets
// - overcurrent_shutdown disables channel, asserts fault, recorded, restart by bus
// - DC offset drives fault_out_n low and outputs high impedance
// - state field in 0x03: 00 deep sleep, 01 sleep, 10 hiz, 11 play
// - target address 01011 plus two strap bits
package pcp_pkg;
    localparam logic [4:0] ADDR_HI       = 5'h0b;
    localparam logic [7:0] REG_PAGE      = 8'h00;
    localparam logic [7:0] REG_STATE     = 8'h03;
    localparam logic [7:0] REG_FAULT     = 8'h70;
    localparam logic [7:0] REG_FAULT_CLR = 8'h78;
    localparam logic [7:0] REG_XOR       = 8'h7d;
    localparam logic [7:0] REG_CRC       = 8'h7e;
    localparam logic [7:0] REG_BOOK      = 8'h7f;
    localparam logic [7:0] BOOK_CTRL     = 8'h00;
    localparam logic [7:0] BOOK_XOR      = 8'h8c;
    localparam logic [7:0] CRC_POLY      = 8'h07;
    localparam logic [7:0] CKS_RST       = 8'h00;
    localparam logic [7:0] PAGE_RST      = 8'h00;
    localparam logic [7:0] BOOK_RST      = 8'h00;
    localparam int         FLT_DC_BIT    = 2;
    typedef enum logic [1:0] {
        PCP_DEEP_SLEEP = 2'b00,
        PCP_SLEEP      = 2'b01,
        PCP_HIZ        = 2'b10,
        PCP_PLAY       = 2'b11
    } pcp_state_e;
    localparam pcp_state_e STATE_RST = PCP_DEEP_SLEEP;
    typedef struct packed {
        logic       stb;
        logic [7:0] addr;
        logic [7:0] data;
    } pcp_wr_s;
endpackage

// ==== design/pcp_sync.sv ====
// two-flop synchroniser for asynchronous pins
// assumes inputs may change at any time relative to CLOCK
`timescale 1ns/100ps
`default_nettype none
module pcp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== design/pcp_checksum.sv ====
// CRC-8 and XOR write checksums
// assumes qualifying enables are decoded by the caller
`timescale 1ns/100ps
`default_nettype none
module pcp_checksum
    import pcp_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire pcp_pkg::pcp_wr_s wr,
    input  wire logic          crc_en,
    input  wire logic          crc_ld,
    input  wire logic          xor_en,
    input  wire logic          xor_ld,
    output var  logic [7:0]    crc_q,
    output var  logic [7:0]    xor_q
);
    import pcp_pkg::*;

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[7] ^ d[i]) ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_q <= CKS_RST;
        end else if (wr.stb && crc_ld) begin
            crc_q <= wr.data;
        end else if (wr.stb && crc_en) begin
            crc_q <= crc_step(crc_q, wr.data);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xor_q <= CKS_RST;
        end else if (wr.stb && xor_ld) begin
            xor_q <= wr.data;
        end else if (wr.stb && xor_en) begin
            xor_q <= xor_q ^ wr.data;
        end
    end
endmodule
`default_nettype wire

// ==== design/pcp_top.sv ====
// two-wire target control port with book/page map, checksums and faults
// assumes SCL, SDA, strap and fault detectors are asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module pcp_top
    import pcp_pkg::*;
#(
    parameter int NCH = 2
) (
    input  wire logic           CLOCK,
    input  wire logic           NRST,
    input  wire logic           SCL_I,
    input  wire logic           SDA_I,
    output var  logic           SDA_O,
    output var  logic           SDA_OE,
    input  wire logic [1:0]     ADDR_SEL,
    input  wire logic [NCH-1:0] OC_EVENT,
    input  wire logic           DC_DETECT,
    output var  logic           FAULT_OUT_N_O,
    output var  logic           FAULT_OUT_N_OE,
    output var  logic [NCH-1:0] CH_ENABLE,
    output var  logic           OUT_HIZ,
    output var  logic [1:0]     DEVICE_STATE
);
    import pcp_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACKA, ST_WR, ST_ACKW, ST_RD, ST_RACK
    } pcp_fsm_e;

    logic [NCH+4:0] pin_s;
    logic           scl_s, sda_s, dc_s;
    logic [1:0]     adr_s;
    logic [NCH-1:0] oc_s;
    logic           scl_p_q, sda_p_q;
    logic           scl_rise, scl_fall, start, stop;
    pcp_fsm_e       st_q;
    logic [2:0]     cnt_q;
    logic [7:0]     sh_q, ptr_q;
    logic           done_q, rw_q, first_q, nack_q, sda_oe_q;
    pcp_wr_s        wr_q;
    logic           rd_go;
    logic [7:0]     rd_mux;
    logic [7:0]     page_q, book_q;
    pcp_state_e     dstate_q;
    logic [1:0]     adr_q;
    logic [1:0]     adr_cnt_q;
    logic           pins_ok;
    logic [NCH-1:0] oc_q;
    logic           dc_q, fault_oe_q, hiz_q;
    logic [NCH-1:0] chen_q;
    logic [7:0]     crc_w, xor_w;
    logic           ctl_pg, pg0, crc_en, crc_ld, xor_en, xor_ld;

    pcp_sync #(.W(NCH + 5)) u_sync (
        .clk   (CLOCK),
        .rst_n (NRST),
        .d     ({SCL_I, SDA_I, DC_DETECT, ADDR_SEL, OC_EVENT}),
        .q     (pin_s)
    );
    assign {scl_s, sda_s, dc_s, adr_s, oc_s} = pin_s;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // bus edge and condition detect
    // sync flops reset low: ignore pins until they settle
    assign pins_ok  = (adr_cnt_q == 2'h3);
    assign scl_rise = pins_ok & scl_s & ~scl_p_q;
    assign scl_fall = pins_ok & ~scl_s & scl_p_q;
    assign start    = pins_ok & scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop     = pins_ok & scl_s & scl_p_q & ~sda_p_q & sda_s;

    // strap taken once the synchroniser has settled
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            adr_q     <= 2'b00;
            adr_cnt_q <= 2'h0;
        end else if (adr_cnt_q != 2'h3) begin
            adr_q     <= adr_s;
            adr_cnt_q <= adr_cnt_q + 2'h1;
        end
    end

    assign pg0    = (page_q == PAGE_RST);
    assign ctl_pg = pg0 && (book_q == BOOK_CTRL);

    always_comb begin
        rd_mux = 8'h00;
        if (ptr_q == REG_PAGE) begin
            rd_mux = page_q;
        end else if (pg0 && ptr_q == REG_BOOK) begin
            rd_mux = book_q;
        end else if (pg0 && ptr_q == REG_CRC) begin
            rd_mux = crc_w;
        end else if (pg0 && book_q == BOOK_XOR && ptr_q == REG_XOR) begin
            rd_mux = xor_w;
        end else if (ctl_pg && ptr_q == REG_STATE) begin
            rd_mux = {6'h00, dstate_q};
        end else if (ctl_pg && ptr_q == REG_FAULT) begin
            rd_mux = 8'(({dc_q, oc_q}));
        end
    end

    assign rd_go = scl_fall && !start && !stop
                   && ((st_q == ST_ACKA && rw_q) || (st_q == ST_RACK && !nack_q));

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            st_q     <= ST_IDLE;
            cnt_q    <= 3'h0;
            sh_q     <= 8'h00;
            ptr_q    <= 8'h00;
            done_q   <= 1'b0;
            rw_q     <= 1'b0;
            first_q  <= 1'b0;
            nack_q   <= 1'b0;
            sda_oe_q <= 1'b0;
            wr_q     <= '0;
        end else begin
            wr_q.stb <= 1'b0;
            if (start) begin
                st_q     <= ST_ADDR;
                cnt_q    <= 3'h0;
                done_q   <= 1'b0;
                sda_oe_q <= 1'b0;
            end else if (stop) begin
                st_q     <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end else if (rd_go) begin
                st_q     <= ST_RD;
                sh_q     <= rd_mux;
                ptr_q    <= ptr_q + 8'h01;
                sda_oe_q <= ~rd_mux[7];
                cnt_q    <= 3'h0;
            end else begin
                case (st_q)
                    ST_ADDR, ST_WR: begin
                        if (scl_rise) begin
                            sh_q   <= {sh_q[6:0], sda_s};
                            cnt_q  <= cnt_q + 3'h1;
                            done_q <= (cnt_q == 3'h7);
                        end else if (scl_fall && done_q) begin
                            done_q <= 1'b0;
                            if (st_q == ST_ADDR) begin
                                if (sh_q[7:1] == {ADDR_HI, adr_q}) begin
                                    st_q     <= ST_ACKA;
                                    rw_q     <= sh_q[0];
                                    first_q  <= ~sh_q[0];
                                    sda_oe_q <= 1'b1;
                                end else begin
                                    st_q <= ST_IDLE;
                                end
                            end else begin
                                st_q     <= ST_ACKW;
                                sda_oe_q <= 1'b1;
                                if (first_q) begin
                                    ptr_q   <= sh_q;
                                    first_q <= 1'b0;
                                end else begin
                                    wr_q.stb  <= 1'b1;
                                    wr_q.addr <= ptr_q;
                                    wr_q.data <= sh_q;
                                    ptr_q     <= ptr_q + 8'h01;
                                end
                            end
                        end
                    end
                    ST_ACKA, ST_ACKW: begin
                        if (scl_fall) begin
                            st_q     <= ST_WR;
                            sda_oe_q <= 1'b0;
                            cnt_q    <= 3'h0;
                        end
                    end
                    ST_RD: begin
                        if (scl_fall) begin
                            cnt_q <= cnt_q + 3'h1;
                            if (cnt_q == 3'h7) begin
                                st_q     <= ST_RACK;
                                sda_oe_q <= 1'b0;
                            end else begin
                                sh_q     <= {sh_q[6:0], 1'b0};
                                sda_oe_q <= ~sh_q[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            nack_q <= sda_s;
                        end else if (scl_fall) begin
                            st_q <= ST_IDLE;
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    assign SDA_O  = 1'b0;
    assign SDA_OE = sda_oe_q;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            page_q <= PAGE_RST;
            book_q <= BOOK_RST;
        end else if (wr_q.stb) begin
            if (wr_q.addr == REG_PAGE) begin
                page_q <= wr_q.data;
            end else if (pg0 && wr_q.addr == REG_BOOK) begin
                book_q <= wr_q.data;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            dstate_q <= STATE_RST;
        end else if (wr_q.stb && ctl_pg && wr_q.addr == REG_STATE) begin
            dstate_q <= pcp_state_e'(wr_q.data[1:0]);
        end
    end

    // sticky faults, set wins over clear
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            oc_q <= '0;
            dc_q <= 1'b0;
        end else begin
            if (wr_q.stb && ctl_pg && wr_q.addr == REG_FAULT_CLR) begin
                oc_q <= (oc_q & ~wr_q.data[NCH-1:0]) | oc_s;
                dc_q <= (dc_q & ~wr_q.data[FLT_DC_BIT]) | dc_s;
            end else begin
                oc_q <= oc_q | oc_s;
                dc_q <= dc_q | dc_s;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            fault_oe_q <= 1'b0;
            hiz_q      <= 1'b1;
            chen_q     <= '0;
        end else begin
            fault_oe_q <= (|oc_q) | (|oc_s) | dc_q | dc_s;
            hiz_q      <= dc_q | dc_s | (dstate_q != PCP_PLAY);
            chen_q     <= ~(oc_q | oc_s) & {NCH{dstate_q == PCP_PLAY && !dc_q && !dc_s}};
        end
    end

    assign FAULT_OUT_N_O  = 1'b0;
    assign FAULT_OUT_N_OE = fault_oe_q;
    assign CH_ENABLE      = chen_q;
    assign OUT_HIZ        = hiz_q;
    assign DEVICE_STATE   = dstate_q;

    assign crc_ld = pg0 && wr_q.addr == REG_CRC;
    assign crc_en = wr_q.addr != REG_PAGE && !(pg0 && wr_q.addr == REG_BOOK);
    assign xor_ld = pg0 && book_q == BOOK_XOR && wr_q.addr == REG_XOR;
    assign xor_en = book_q == BOOK_XOR && !pg0 && wr_q.addr != REG_PAGE;

    pcp_checksum u_cks (
        .clk    (CLOCK),
        .rst_n  (NRST),
        .wr     (wr_q),
        .crc_en (crc_en),
        .crc_ld (crc_ld),
        .xor_en (xor_en),
        .xor_ld (xor_ld),
        .crc_q  (crc_w),
        .xor_q  (xor_w)
    );

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    sequence s_fault_seen;
        ##[1:2] fault_oe_q;
    endsequence

    AST_WR_ACK: assert property (wr_q.stb |-> st_q == ST_ACKW && sda_oe_q && ptr_q == wr_q.addr + 8'h01)
        else $error("write byte not acked or pointer not advanced");
    AST_RD_LOAD: assert property (rd_go |=> st_q == ST_RD && sh_q == $past(rd_mux) && ptr_q == $past(ptr_q) + 8'h01)
        else $error("read byte not loaded from pointer");
    AST_BOOK_GATE: assert property (wr_q.stb && wr_q.addr == REG_BOOK && !pg0 |=> book_q == $past(book_q))
        else $error("book changed off page zero");
    AST_PAGE_SEL: assert property (wr_q.stb && wr_q.addr == REG_PAGE |=> page_q == $past(wr_q.data))
        else $error("page select not taken");
    AST_CRC_SKIP: assert property (wr_q.stb && wr_q.addr == REG_PAGE |=> $stable(crc_w))
        else $error("crc moved on page select");
    AST_CRC_RST: assert property (wr_q.stb && crc_ld && wr_q.data == CKS_RST |=> crc_w == CKS_RST)
        else $error("crc not reset");
    AST_RD_NOCKS: assert property (rd_go |=> $stable(crc_w) && $stable(xor_w))
        else $error("checksum moved on read");
    AST_XOR_ACC: assert property (wr_q.stb && xor_en |=> xor_w == ($past(xor_w) ^ $past(wr_q.data)))
        else $error("xor checksum not accumulated");
    AST_XOR_BOOK: assert property (wr_q.stb && book_q != BOOK_XOR |=> $stable(xor_w))
        else $error("xor moved outside its book");
    AST_OC_OFF: assert property (oc_s[0] |-> s_fault_seen ##0 !CH_ENABLE[0])
        else $error("overcurrent did not disable channel");
    AST_DC_HIZ: assert property (dc_s |-> s_fault_seen ##0 OUT_HIZ)
        else $error("dc offset did not fault and float outputs");
    AST_ADDR_MATCH: assert property ($rose(st_q == ST_ACKA) |-> $past(sh_q[7:1]) == {ADDR_HI, adr_q})
        else $error("acked wrong target address");
endmodule
`default_nettype wire

// ==== tb/pcp_host.sv ====
// two-wire bus controller model driving the control port
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/100ps
`default_nettype none
module pcp_host #(
    parameter int H = 20
) (
    input  wire logic       clk,
    input  wire logic       sda,
    output var  logic       scl,
    output var  logic       sda_low,
    output var  logic [7:0] res_val,
    output var  logic       res_tgl
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        res_val = 8'h00;
        res_tgl = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one bit per link period, sampled mid-high
    task automatic bitx(input logic b, output logic s);
        sda_low <= ~b;
        tick(H / 2);
        scl <= 1'b1;
        tick(H / 2);
        s = sda;
        tick(H / 2);
        scl <= 1'b0;
        tick(H / 2);
    endtask
    task automatic start();
        sda_low <= 1'b0;
        tick(H / 2);
        scl <= 1'b1;
        tick(H);
        sda_low <= 1'b1;
        tick(H);
        scl <= 1'b0;
        tick(H / 2);
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        tick(H / 2);
        scl <= 1'b1;
        tick(H);
        sda_low <= 1'b0;
        tick(H);
    endtask
    task automatic wbyte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'b1, s);
        res_val <= {7'h00, s};
        res_tgl <= ~res_tgl;
    endtask
    // acknowledge all but the last byte
    task automatic rbyte(input logic last);
        logic [7:0] v;
        logic       s;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, s);
            v[i] = s;
        end
        bitx(last, s);
        res_val <= v;
        res_tgl <= ~res_tgl;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the paged control port
// assumes pcp_host as bus controller and a pulled-up data line
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pcp_pkg::*;
    logic       clock;
    logic       nrst;
    logic [1:0] sel;
    logic [1:0] oc;
    logic       dc;
    logic       scl;
    logic       host_low;
    logic       sda_o;
    logic       sda_oe;
    logic       flt_o;
    logic       flt_oe;
    logic [1:0] ch_en;
    logic       hiz;
    logic [1:0] st;
    logic [7:0] res_val;
    logic       res_tgl;
    logic [6:0] dev;
    wire        sda = ~(host_low | (sda_oe & ~sda_o));
    int         n_mismatch = 0;
    int         checked = 0;
    integer     seed = 38;
    logic [7:0] expq[$];
    logic [7:0] crc = 8'h00;
    logic [7:0] xsum = 8'h00;
    logic [7:0] page = 8'h00;
    logic [7:0] book = 8'h00;

    pcp_top dut (
        .CLOCK          (clock),
        .NRST           (nrst),
        .SCL_I          (scl),
        .SDA_I          (sda),
        .SDA_O          (sda_o),
        .SDA_OE         (sda_oe),
        .ADDR_SEL       (sel),
        .OC_EVENT       (oc),
        .DC_DETECT      (dc),
        .FAULT_OUT_N_O  (flt_o),
        .FAULT_OUT_N_OE (flt_oe),
        .CH_ENABLE      (ch_en),
        .OUT_HIZ        (hiz),
        .DEVICE_STATE   (st)
    );
    pcp_host host (
        .clk     (clock),
        .sda     (sda),
        .scl     (scl),
        .sda_low (host_low),
        .res_val (res_val),
        .res_tgl (res_tgl)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(res_tgl) begin
        if (nrst === 1'b1) begin
            if (expq.size() == 0) begin
                n_mismatch++;
                $display("unexpected bus result: expected none, seen %h", res_val);
            end else begin
                chk("bus result", res_val, expq.pop_front());
            end
        end
    end

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction
    task automatic model(input logic [7:0] a, input logic [7:0] b);
        logic p0;
        p0 = (page == 8'h00);
        if (a == REG_PAGE) page = b;
        else if (p0 && a == REG_BOOK) book = b;
        else if (p0 && a == REG_CRC) crc = b;
        else begin
            crc = crc8(crc, b);
            if (book == BOOK_XOR && p0 && a == REG_XOR) xsum = b;
            else if (book == BOOK_XOR && !p0) xsum ^= b;
        end
    endtask
    task automatic adr(input logic [7:0] ptr);
        host.start();
        expq.push_back(8'h00);
        host.wbyte({dev, 1'b0});
        expq.push_back(8'h00);
        host.wbyte(ptr);
    endtask
    task automatic bwrite(input logic [7:0] ptr, input logic [7:0] d[$]);
        logic [7:0] a;
        a = ptr;
        adr(ptr);
        foreach (d[i]) begin
            expq.push_back(8'h00);
            host.wbyte(d[i]);
            model(a, d[i]);
            a++;
        end
        host.stop();
        repeat (4) @(posedge clock);
    endtask
    task automatic w1(input logic [7:0] a, input logic [7:0] b);
        bwrite(a, {b});
    endtask
    task automatic bread(input logic [7:0] ptr, input logic [7:0] e[$]);
        adr(ptr);
        host.start();
        expq.push_back(8'h00);
        host.wbyte({dev, 1'b1});
        foreach (e[i]) begin
            expq.push_back(e[i]);
            host.rbyte(i == e.size() - 1);
        end
        host.stop();
        repeat (4) @(posedge clock);
    endtask

    initial begin
        logic [7:0] r[$];
        nrst <= 1'b0;
        sel <= 2'($random(seed));
        oc <= 2'b00;
        dc <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        repeat (6) @(posedge clock);
        dev = {ADDR_HI, sel};
        chk("state", {6'h00, st}, {6'h00, STATE_RST});
        chk("hiz", {7'h00, hiz}, 8'h01);
        chk("fault", {7'h00, flt_oe}, 8'h00);
        chk("fault pin", {7'h00, flt_o}, 8'h00);
        chk("sda pin", {7'h00, sda_o}, 8'h00);
        host.start();
        expq.push_back(8'h01);
        host.wbyte({ADDR_HI, ~sel, 1'b0});
        host.stop();
        // state walked through hiz before play
        for (int s = 0; s < 4; s++) begin
            w1(REG_STATE, 8'(s));
            chk("state", {6'h00, st}, 8'(s));
            chk("hiz", {7'h00, hiz}, {7'h00, s != 3});
        end
        chk("ch_en", {6'h00, ch_en}, 8'h03);
        bread(REG_CRC, {crc, book});
        w1(REG_CRC, 8'h00);
        r = {8'($random(seed)), 8'($random(seed))};
        bwrite(8'h04, r);
        bread(REG_CRC, {crc});
        // page zero, book, five ascending coefficients
        w1(REG_PAGE, 8'h00);
        w1(REG_BOOK, 8'haa);
        w1(REG_PAGE, 8'h01);
        r = {};
        repeat (5) r.push_back(8'($random(seed)));
        bwrite(8'h08, r);
        w1(REG_PAGE, 8'h00);
        w1(REG_BOOK, BOOK_XOR);
        w1(REG_PAGE, 8'h05);
        // 0x7f off page zero is a plain register
        r = {8'($random(seed)), 8'($random(seed))};
        bwrite(8'h7e, r);
        w1(REG_PAGE, 8'h00);
        bread(REG_XOR, {xsum, crc});
        w1(REG_XOR, 8'h00);
        bread(REG_XOR, {xsum});
        w1(REG_BOOK, BOOK_CTRL);
        oc <= 2'b10;
        repeat (10) @(posedge clock);
        chk("ch_en", {6'h00, ch_en}, 8'h01);
        chk("fault", {7'h00, flt_oe}, 8'h01);
        oc <= 2'b00;
        bread(REG_FAULT, {8'h02});
        w1(REG_FAULT_CLR, 8'h02);
        chk("ch_en", {6'h00, ch_en}, 8'h03);
        chk("fault", {7'h00, flt_oe}, 8'h00);
        dc <= 1'b1;
        repeat (10) @(posedge clock);
        chk("hiz", {7'h00, hiz}, 8'h01);
        chk("fault", {7'h00, flt_oe}, 8'h01);
        dc <= 1'b0;
        bread(REG_FAULT, {8'h04});
        w1(REG_FAULT_CLR, 8'h04);
        chk("hiz", {7'h00, hiz}, 8'h00);
        w1(REG_STATE, {6'h00, PCP_HIZ});
        chk("hiz", {7'h00, hiz}, 8'h01);
        repeat (20) @(posedge clock);
        // mid-run reset clears map and checksums
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        crc  = CKS_RST;
        xsum = CKS_RST;
        page = PAGE_RST;
        book = BOOK_RST;
        repeat (6) @(posedge clock);
        chk("state", {6'h00, st}, {6'h00, STATE_RST});
        chk("hiz", {7'h00, hiz}, 8'h01);
        bread(REG_CRC, {crc, book});
        chk("pending", 8'(expq.size()), 8'h00);
        complete_run();
    end

    initial begin
        repeat (70000) @(posedge clock);
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire
